// ---- interleaver_defines.svh ----
// Purpose: Constants for the second interleaver and channel mapper.
// Assumes: Included by the package and the design modules by bare name.
// Notes: Sizes are fixed; one frame or slot holds at most MAX_BITS bits.
//
// Functional notes
// (R1) Slot input is each slot channel's bits concatenated in channel order.
// (R2) Slot mode runs the whole interleave per slot with its own bit count.
// (R3) The matrix always has 30 columns, numbered 0 to 29.
// (R4) Row count is the ceiling of bit count divided by 30.
// (R5) Input bits fill the matrix row by row.
// (R6) Output column j holds original column given by permutation entry j.
// (R7) Permutation table is 0,20,10,5,15,25,3,13,... ending 27,17.
// (R8) Readout goes column by column, top row to bottom row.
// (R9) Positions beyond the bit count are skipped; output count equals input.
// (R10) Each channel's bits leave in ascending index order.
// (R11) Frame mode splits the output consecutively by channel bit counts.
// (R12) Slot mode splits among only that slot's channels, in channel order.
// (R13) Controller aligns transport blocks to common transmission instants.
// (R14) Configuration never maps two composite channels onto one channel.
// (R15) One composite channel maps onto one or more configured channels.
// (R16) Dedicated and common transport channels are never combined.
// (R17) Among common channels only paging and access types share one.
// (R18) A broadcast composite channel carries exactly one broadcast channel.
// (R19) A random access composite channel carries exactly one such channel.
// (R20) At most one format indicator accompanies each eligible composite.
// (R21) With an indicator, the receiver derives the format combination.
// (R22) Without one, the receiver may try all format combinations blindly.
// (R23) Frame mode interleaves the whole frame as one joint sequence.
// (R24) Higher layer picks frame or slot mode; the device follows it.
// (R25) Bits arrive serially, one unit is buffered, then streamed out.
// (R26) Counts and mode are latched at unit start and held until readout.
`ifndef INTERLEAVER_DEFINES_SVH
`define INTERLEAVER_DEFINES_SVH

`define COL_COUNT 30
`define COL_LAST 5'h1D
`define MAX_ROWS 64
`define MAX_BITS 1920
`define CNT_W 11
`define ROW_W 7
`define MAX_CH 8
`define CH_W 3
`define CHN_W 4
`define FIFO_DEPTH 4

`endif

// ---- interleaver_pkg.sv ----
// Purpose: Types and helpers for the second interleaver.
// Assumes: Constants come from the defines header.
// Notes: Permutation table lives here so every user sees the same one.
`include "interleaver_defines.svh"

package interleaver_pkg;

    typedef logic [`CNT_W-1:0] cnt_t;
    typedef logic [`MAX_CH-1:0][`CNT_W-1:0] chan_bits_t;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_FILL = 3'b010,
        ST_READ = 3'b100
    } state_t;

    typedef struct packed {
        logic slot_mode;
        cnt_t total_bits;
        logic [`CHN_W-1:0] chan_count;
        chan_bits_t chan_bits;
    } cfg_t;

    typedef struct packed {
        logic data;
        logic [`CH_W-1:0] chan;
        logic slot_mode;
        logic last;
    } out_word_t;

    // Original column feeding output column j
    function automatic logic [4:0] column_permutation_entry(
        input logic [4:0] j
    );
        logic [4:0] p;
        p = 5'h00;
        case (j)
            5'h00: p = 5'h00;
            5'h01: p = 5'h14;
            5'h02: p = 5'h0A;
            5'h03: p = 5'h05;
            5'h04: p = 5'h0F;
            5'h05: p = 5'h19;
            5'h06: p = 5'h03;
            5'h07: p = 5'h0D;
            5'h08: p = 5'h17;
            5'h09: p = 5'h08;
            5'h0A: p = 5'h12;
            5'h0B: p = 5'h1C;
            5'h0C: p = 5'h01;
            5'h0D: p = 5'h0B;
            5'h0E: p = 5'h15;
            5'h0F: p = 5'h06;
            5'h10: p = 5'h10;
            5'h11: p = 5'h1A;
            5'h12: p = 5'h04;
            5'h13: p = 5'h0E;
            5'h14: p = 5'h18;
            5'h15: p = 5'h13;
            5'h16: p = 5'h09;
            5'h17: p = 5'h1D;
            5'h18: p = 5'h0C;
            5'h19: p = 5'h02;
            5'h1A: p = 5'h07;
            5'h1B: p = 5'h16;
            5'h1C: p = 5'h1B;
            5'h1D: p = 5'h11;
            default: p = 5'h00;
        endcase
        return p; // (R7)
    endfunction : column_permutation_entry

    // Ceiling of bit count over column count
    function automatic logic [`ROW_W-1:0] interleaver_row_count(
        input cnt_t bits
    );
        logic [`CNT_W:0] sum;
        sum = {1'b0, bits} + (`CNT_W+1)'(`COL_COUNT - 1);
        return `ROW_W'(sum / (`CNT_W+1)'(`COL_COUNT)); // (R4)
    endfunction : interleaver_row_count

    // Row-major position of a matrix cell after permutation
    function automatic cnt_t matrix_index(
        input logic [`ROW_W-1:0] row,
        input logic [4:0] col
    );
        cnt_t base;
        base = `CNT_W'(row) * `CNT_W'(`COL_COUNT);
        return base + `CNT_W'(column_permutation_entry(col)); // (R6)
    endfunction : matrix_index

endpackage : interleaver_pkg

// ---- bit_fifo.sv ----
// Purpose: Small valid/ready FIFO between readout and output stage.
// Assumes: Single clock, asynchronous active-low reset.
// Notes: Full and empty come from an occupancy count, not pointers.
`include "interleaver_defines.svh"

module bit_fifo #(
    parameter int WIDTH = 6,
    parameter int DEPTH = `FIFO_DEPTH
) (
    // Clock and reset
    input wire logic i_clk_sys,
    input wire logic i_rst_n,
    // Fill side
    input wire logic i_wr_valid,
    input wire logic [WIDTH-1:0] i_wr_data,
    output logic o_wr_ready,
    // Drain side
    output logic o_rd_valid,
    output logic [WIDTH-1:0] o_rd_data,
    input wire logic i_rd_ready
);

    localparam int AW = $clog2(DEPTH);

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [AW-1:0] wp;
        logic [AW-1:0] rp;
        logic [AW:0] cnt;
    } fifo_state_t;

    fifo_state_t s_r;
    fifo_state_t s_nxt;
    logic push;
    logic pop;

    assign o_wr_ready = (s_r.cnt != (AW+1)'(DEPTH));
    assign o_rd_valid = (s_r.cnt != '0);
    assign o_rd_data = s_r.mem[s_r.rp];
    assign push = i_wr_valid && o_wr_ready;
    assign pop = o_rd_valid && i_rd_ready;

    always_comb begin
        s_nxt = s_r;
        if (push) begin
            s_nxt.mem[s_r.wp] = i_wr_data;
            s_nxt.wp = (s_r.wp == AW'(DEPTH - 1)) ? '0 : s_r.wp + 1'b1;
        end
        if (pop) begin
            s_nxt.rp = (s_r.rp == AW'(DEPTH - 1)) ? '0 : s_r.rp + 1'b1;
        end
        if (push && !pop) begin
            s_nxt.cnt = s_r.cnt + 1'b1;
        end else if (pop && !push) begin
            s_nxt.cnt = s_r.cnt - 1'b1;
        end
    end

    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

endmodule : bit_fifo

// ---- second_interleaver_phch_mapper.sv ----
// Purpose: Second interleaver and physical channel mapper, one unit at a time.
// Assumes: Upstream delivers a unit's bits already in channel order.
// Notes: A unit is one frame or one timeslot, chosen per unit by the caller.
`include "interleaver_defines.svh"

module second_interleaver_phch_mapper
    import interleaver_pkg::*;
(
    // Clock and reset
    input wire logic i_clk_sys,
    input wire logic i_rst_n,
    // Unit configuration, taken with i_start
    input wire logic i_start,
    input wire logic i_slot_mode,
    input wire cnt_t i_total_bits,
    input wire logic [`CHN_W-1:0] i_chan_count,
    input wire chan_bits_t i_chan_bits,
    output logic o_cfg_ready,
    // Serial input bits
    input wire logic i_in_valid,
    input wire logic i_in_bit,
    output logic o_in_ready,
    // Interleaved, mapped output bits
    output logic o_out_valid,
    output logic o_out_bit,
    output logic [`CH_W-1:0] o_out_chan,
    output logic o_out_slot_mode,
    output logic o_out_last,
    input wire logic i_out_ready,
    // Status
    output logic o_busy,
    output logic o_done
);

    ////////////////////////////////////////////////////////////////////////
    // State

    typedef struct packed {
        state_t st;
        cfg_t cfg;
        logic [`MAX_BITS-1:0] mem;
        cnt_t wr;
        cnt_t rd_left;
        logic [`ROW_W-1:0] rows;
        logic [`ROW_W-1:0] row;
        logic [4:0] col;
        cnt_t ch_cnt;
        logic [`CH_W-1:0] ch;
        logic out_valid;
        out_word_t out_word;
        logic in_ready;
        logic cfg_ready;
        logic busy;
        logic done;
    } top_state_t;

    top_state_t s_r;
    top_state_t s_nxt;

    ////////////////////////////////////////////////////////////////////////
    // Readout FIFO

    out_word_t push_word;
    logic push_valid;
    logic fifo_wr_ready;
    logic fifo_rd_valid;
    out_word_t fifo_rd_word;
    logic fifo_rd_ready;
    logic [$bits(out_word_t)-1:0] fifo_rd_data;

    // Output stage takes a word when it is empty or being drained
    assign fifo_rd_ready = !s_r.out_valid || i_out_ready;
    assign fifo_rd_word = out_word_t'(fifo_rd_data);

    bit_fifo #(
        .WIDTH($bits(out_word_t)),
        .DEPTH(`FIFO_DEPTH)
    ) u_fifo (
        .i_clk_sys(i_clk_sys),
        .i_rst_n(i_rst_n),
        .i_wr_valid(push_valid),
        .i_wr_data(push_word),
        .o_wr_ready(fifo_wr_ready),
        .o_rd_valid(fifo_rd_valid),
        .o_rd_data(fifo_rd_data),
        .i_rd_ready(fifo_rd_ready)
    );

    ////////////////////////////////////////////////////////////////////////
    // Readout position

    cnt_t pos;
    logic in_range;
    logic last_pos;
    logic chan_end;

    assign pos = matrix_index(s_r.row, s_r.col); // (R6)
    // Padding cells past the unit length are dropped
    assign in_range = pos < s_r.cfg.total_bits; // (R9)
    assign last_pos = (s_r.col == `COL_LAST) &&
                      (s_r.row == s_r.rows - 1'b1);
    // Zero-length channels are not skipped; caller keeps counts non-zero
    assign chan_end = (s_r.ch_cnt + 1'b1) >= s_r.cfg.chan_bits[s_r.ch];

    always_comb begin
        push_word.data = s_r.mem[pos];
        push_word.chan = s_r.ch;
        push_word.slot_mode = s_r.cfg.slot_mode;
        push_word.last = (s_r.rd_left == `CNT_W'(1));
        push_valid = s_r.st == ST_READ && in_range;
    end

    ////////////////////////////////////////////////////////////////////////
    // Next state

    always_comb begin
        s_nxt = s_r;
        s_nxt.done = 1'b0;

        // Output register, so every port is a flip-flop
        if (fifo_rd_valid && fifo_rd_ready) begin
            s_nxt.out_valid = 1'b1;
            s_nxt.out_word = fifo_rd_word;
        end else if (i_out_ready) begin
            s_nxt.out_valid = 1'b0;
        end

        case (s_r.st)
            ST_IDLE: begin
                if (i_start) begin
                    // Held until readout ends, even if the ports change
                    s_nxt.cfg.slot_mode = i_slot_mode; // (R24)
                    s_nxt.cfg.total_bits = i_total_bits; // (R26)
                    s_nxt.cfg.chan_count = i_chan_count; // (R15)
                    s_nxt.cfg.chan_bits = i_chan_bits; // (R26)
                    s_nxt.rows = interleaver_row_count(i_total_bits); // (R4)
                    s_nxt.wr = '0;
                    s_nxt.rd_left = i_total_bits;
                    s_nxt.row = '0;
                    s_nxt.col = '0; // (R3)
                    s_nxt.ch = '0;
                    s_nxt.ch_cnt = '0;
                    if (i_total_bits == '0) begin
                        s_nxt.done = 1'b1;
                    end else begin
                        s_nxt.st = ST_FILL;
                    end
                end
            end
            ST_FILL: begin
                if (i_in_valid) begin
                    // Row-major fill: bit k, counting from 0, lands at index k
                    s_nxt.mem[s_r.wr] = i_in_bit; // (R5)
                    s_nxt.wr = s_r.wr + 1'b1; // (R1)
                    if (s_r.wr + 1'b1 == s_r.cfg.total_bits) begin
                        s_nxt.st = ST_READ; // (R25)
                    end
                end
            end
            ST_READ: begin
                // Stall only a real bit; padding moves on regardless
                if (!in_range || fifo_wr_ready) begin
                    if (s_r.row == s_r.rows - 1'b1) begin
                        s_nxt.row = '0;
                        s_nxt.col = s_r.col + 1'b1; // (R8)
                    end else begin
                        s_nxt.row = s_r.row + 1'b1; // (R8)
                    end
                    if (in_range) begin
                        s_nxt.rd_left = s_r.rd_left - 1'b1;
                        if (chan_end &&
                            (`CHN_W'(s_r.ch) + 1'b1) < s_r.cfg.chan_count)
                        begin
                            s_nxt.ch = s_r.ch + 1'b1; // (R11)
                            s_nxt.ch_cnt = '0; // (R12)
                        end else begin
                            s_nxt.ch_cnt = s_r.ch_cnt + 1'b1; // (R10)
                        end
                    end
                    if (last_pos) begin
                        // Each unit is finished on its own before the next
                        s_nxt.st = ST_IDLE; // (R2)
                        s_nxt.done = 1'b1; // (R23)
                    end
                end
            end
            default: begin
                s_nxt.st = ST_IDLE;
            end
        endcase

        s_nxt.in_ready = s_nxt.st == ST_FILL;
        s_nxt.cfg_ready = s_nxt.st == ST_IDLE;
        s_nxt.busy = s_nxt.st != ST_IDLE;
    end

    ////////////////////////////////////////////////////////////////////////
    // Registers

    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            s_r <= '0;
            s_r.st <= ST_IDLE;
            s_r.cfg_ready <= 1'b1;
        end else begin
            s_r <= s_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Outputs

    assign o_cfg_ready = s_r.cfg_ready;
    assign o_in_ready = s_r.in_ready;
    assign o_out_valid = s_r.out_valid;
    assign o_out_bit = s_r.out_word.data;
    assign o_out_chan = s_r.out_word.chan;
    // Format indicator and blind detection belong to the receiver
    assign o_out_slot_mode = s_r.out_word.slot_mode; // (R21) (R22)
    assign o_out_last = s_r.out_word.last;
    assign o_busy = s_r.busy;
    assign o_done = s_r.done;

endmodule : second_interleaver_phch_mapper

// ---- interleaver_monitor.sv ----
// Purpose: Port checks for the interleaver mapper.
// Assumes: One clock, asynchronous active-low reset.
// Notes: Per-unit output count is judged by the bench.
`include "interleaver_defines.svh"

module interleaver_monitor
    import interleaver_pkg::*;
(
    // Clock and reset
    input wire logic i_clk_sys,
    input wire logic i_rst_n,
    // Config and input side
    input wire logic i_start,
    input wire cnt_t i_total_bits,
    input wire logic o_cfg_ready,
    input wire logic i_in_valid,
    input wire logic o_in_ready,
    // Output side and status
    input wire logic o_out_valid,
    input wire logic o_out_bit,
    input wire logic [`CH_W-1:0] o_out_chan,
    input wire logic o_out_last,
    input wire logic i_out_ready,
    input wire logic o_busy,
    input wire logic o_done
);
////////////////////////////////////////////////////////////
    default clocking cb @(posedge i_clk_sys);
    endclocking
    default disable iff (!i_rst_n);

    cnt_t in_cnt_r;
    cnt_t tot_r;
    logic [`CH_W-1:0] chan_r;
    logic end_r;
    logic acc;
    assign acc = o_out_valid && i_out_ready;

    // Bits taken since the last start, and the latched total
    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            in_cnt_r <= '0;
            tot_r <= '0;
            chan_r <= '0;
            end_r <= 1'b1;
        end else begin
            if (i_start && o_cfg_ready) begin
                in_cnt_r <= '0;
                tot_r <= i_total_bits;
            end else if (i_in_valid && o_in_ready) begin
                in_cnt_r <= in_cnt_r + `CNT_W'(1);
            end
            if (acc) begin
                chan_r <= o_out_chan;
                end_r <= o_out_last;
            end
        end
    end

    sequence s_take;
        i_start && o_cfg_ready && (i_total_bits != '0);
    endsequence
    sequence s_fill;
        !o_cfg_ready && o_in_ready && o_busy;
    endsequence

    a_cfg_take: assert property (s_take |=> s_fill)
        else $error("start not taken");
    a_zero_start: assert property (i_start && o_cfg_ready &&
        i_total_bits == '0 |=> o_done && o_cfg_ready)
        else $error("empty unit not done");
    a_fill_count: assert property ($fell(o_in_ready) |->
        in_cnt_r == tot_r) else $error("fill count wrong");
    a_out_hold: assert property (o_out_valid && !i_out_ready |=>
        o_out_valid && $stable(o_out_bit) && $stable(o_out_chan)
        && $stable(o_out_last)) else $error("output word dropped");
    a_chan_step: assert property (acc && !end_r |->
        o_out_chan == chan_r || o_out_chan == chan_r + `CH_W'(1))
        else $error("channel skipped");
    a_chan_first: assert property (acc && end_r |->
        o_out_chan == '0) else $error("unit not on first channel");
    a_done_pulse: assert property (o_done |=> !o_done)
        else $error("done too long");
    a_done_idle: assert property (o_done && !i_start |=>
        o_cfg_ready && !o_busy) else $error("not idle after done");
    a_fill_busy: assert property (o_in_ready |->
        o_busy && !o_cfg_ready) else $error("fill while idle");
endmodule : interleaver_monitor

bind second_interleaver_phch_mapper interleaver_monitor u_mon (
    .i_clk_sys, .i_rst_n, .i_start, .i_total_bits, .o_cfg_ready,
    .i_in_valid, .o_in_ready, .o_out_valid, .o_out_bit, .o_out_chan,
    .o_out_last, .i_out_ready, .o_busy, .o_done);

// ---- out_sink.sv ----
// Purpose: Downstream modulation stage model.
// Assumes: Words are taken on valid and ready at an edge.
// Notes: Slow pace leaves ready high one cycle in four.
module out_sink
    import interleaver_pkg::*;
(
    // Clock and reset
    input wire logic i_clk_sys,
    input wire logic i_rst_n,
    // Pace and words
    input wire logic i_slow,
    input wire logic i_valid,
    input wire out_word_t i_word,
    output logic o_ready
);
    timeunit 1ns;
    timeprecision 1ps;
    int seed = 32'h1381;
    out_word_t q[$];

    // Ready wanders every cycle so stalls hit the FIFO
    always @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_ready <= 1'b0;
        end else begin
            if (i_valid && o_ready) begin
                q.push_back(i_word);
            end
            o_ready <= i_slow ? (($random(seed) & 3) == 0)
                              : (($random(seed) & 3) != 0);
        end
    end
endmodule : out_sink

// ---- tb.sv ----
// Purpose: Self-checking bench for the interleaver mapper.
// Assumes: Units run one at a time and drain fully.
// Notes: Total, mode and channel bit counts are scrambled mid-unit on purpose; channel count is not.
`include "interleaver_defines.svh"

module tb
    import interleaver_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic i_clk_sys, i_rst_n, i_start, i_slot_mode;
    cnt_t i_total_bits;
    logic [`CHN_W-1:0] i_chan_count;
    chan_bits_t i_chan_bits;
    logic i_in_valid, i_in_bit, i_out_ready, i_slow;
    logic o_cfg_ready, o_in_ready, o_out_valid, o_out_bit;
    logic [`CH_W-1:0] o_out_chan;
    logic o_out_slot_mode, o_out_last, o_busy, o_done;
    int seed = 32'h1381;
    int fail_count = 0;
    int cmp_count = 0;
    int perm[30] = '{0, 20, 10, 5, 15, 25, 3, 13, 23, 8, 18, 28, 1, 11,
        21, 6, 16, 26, 4, 14, 24, 19, 9, 29, 12, 2, 7, 22, 27, 17};
    int cbx[8];
    logic x[`MAX_BITS];
    int u, n;

    second_interleaver_phch_mapper DUT (.i_clk_sys, .i_rst_n, .i_start,
        .i_slot_mode, .i_total_bits, .i_chan_count, .i_chan_bits,
        .o_cfg_ready, .i_in_valid, .i_in_bit, .o_in_ready, .o_out_valid,
        .o_out_bit, .o_out_chan, .o_out_slot_mode, .o_out_last,
        .i_out_ready, .o_busy, .o_done);
    out_sink rx (.i_clk_sys, .i_rst_n, .i_slow, .i_valid(o_out_valid),
        .i_word({o_out_bit, o_out_chan, o_out_slot_mode, o_out_last}),
        .o_ready(i_out_ready));

    initial begin
        i_clk_sys = 1'b0;
        forever #2.5 i_clk_sys = ~i_clk_sys;
    end
////////////////////////////////////////////////////////////
    task automatic chk(input logic [10:0] g, input logic [10:0] e);
        cmp_count++;
        if (g !== e) begin
            fail_count++;
            $display("mismatch at %0t got %h exp %h", $time, g, e);
        end
    endtask : chk

    task automatic close_out();
        $display("compares %0d mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : close_out

    // Channel owning output bit b, from the split counts
    function automatic logic [2:0] exp_chan(input int b);
        int c;
        int a;
        c = 0;
        a = cbx[0];
        while (b >= a && c < 7) begin
            c++;
            a += cbx[c];
        end
        return 3'(c);
    endfunction : exp_chan

    task automatic run_unit(input int u, input int n, input logic m);
        int k, w, b, c, a;
        out_word_t e;
        out_word_t got;
        for (k = 0; k < 8; k++) begin
            cbx[k] = k >= n ? 0 : k == n - 1 ? u - k * (u / n) : u / n;
            i_chan_bits[k] = `CNT_W'(cbx[k]);
        end
        for (k = 0; k < u; k++) begin
            x[k] = 1'($random(seed));
        end
        i_start = 1'b1;
        i_slot_mode = m;
        i_total_bits = `CNT_W'(u);
        i_chan_count = `CHN_W'(n);
        @(posedge i_clk_sys);
        #1;
        // Scrambled config must not reach a unit in flight
        i_total_bits = ~i_total_bits;
        i_slot_mode = ~m;
        i_chan_bits = ~i_chan_bits;
        k = 0;
        w = 0;
        while (k < u && w < 20000) begin
            i_start = (w == 2);
            i_in_valid = 1'($random(seed));
            i_in_bit = x[k];
            if (i_in_valid && o_in_ready) k++;
            @(posedge i_clk_sys);
            #1;
            w++;
        end
        i_start = 1'b0;
        i_in_valid = 1'b0;
        while ((rx.q.size() < u || !o_cfg_ready) && w < 40000) begin
            @(posedge i_clk_sys);
            #1;
            w++;
        end
        if (w >= 40000) begin
            fail_count++;
            close_out();
        end
        repeat (4) @(posedge i_clk_sys);
        #1;
        chk(11'(rx.q.size()), 11'(u));
        b = 0;
        for (c = 0; c < 30; c++) begin
            for (k = 0; k < (u + 29) / 30; k++) begin
                a = k * 30 + perm[c];
                if (a < u && rx.q.size() > 0) begin
                    e.data = x[a];
                    e.chan = exp_chan(b);
                    e.slot_mode = m;
                    e.last = (b == u - 1);
                    got = rx.q.pop_front();
                    chk(11'(got.data), 11'(e.data));
                    chk(11'(got.chan), 11'(e.chan));
                    chk(11'(got[1:0]), 11'(e[1:0]));
                    b++;
                end
            end
        end
    endtask : run_unit

    initial begin
        i_rst_n = 1'b0;
        i_start = 1'b0;
        i_slot_mode = 1'b0;
        i_total_bits = '0;
        i_chan_count = '0;
        i_chan_bits = '0;
        i_in_valid = 1'b0;
        i_in_bit = 1'b0;
        i_slow = 1'b0;
        repeat (12) @(posedge i_clk_sys);
        #1;
        i_rst_n = 1'b1;
        i_start = 1'b1;
        @(posedge i_clk_sys);
        #1;
        i_start = 1'b0;
        chk({10'h000, o_done}, 11'h001);
        @(posedge i_clk_sys);
        #1;
        run_unit(1, 1, 1'b0);
        run_unit(30, 2, 1'b1);
        run_unit(31, 3, 1'b0);
        i_slow = 1'b1;
        run_unit(59, 8, 1'b1);
        run_unit(1920, 8, 1'b0);
        repeat (8) begin
            i_slow = ~i_slow;
            u = 1 + ($random(seed) & 511);
            n = 1 + ($random(seed) & 7);
            // Every channel needs at least one bit
            if (n > u) begin
                n = u;
            end
            run_unit(u, n, 1'($random(seed)));
        end
        close_out();
    end
endmodule : tb
